// File: hw/ais_regs.sv
// converter input select registers with ahb-lite slave and mux select outputs
`timescale 1ns/1ns
`default_nettype none
module ais_regs #(
   parameter int NUM_INPUTS = 6  // analog inputs present on the part (4 or 6 sensible)
) (
   input wire logic clk_i,                          // 25 MHz system clock
   input wire logic sys_rst_i,                      // synchronous reset, active high
   input wire logic hsel_i,                         // ahb slave select
   input wire logic [31:0] haddr_i,                 // ahb address
   input wire logic [1:0] htrans_i,                 // ahb transfer type
   input wire logic hwrite_i,                       // ahb write
   input wire logic [2:0] hsize_i,                  // ahb size
   input wire logic [31:0] hwdata_i,                // ahb write data
   input wire logic hready_i,                       // ahb bus ready
   output logic [31:0] hrdata_o,                    // ahb read data
   output logic hreadyout_o,                        // ahb slave ready
   output logic hresp_o,                            // ahb response, always okay
   input wire logic alt_sample_i,                   // sequencer: 1 selects sample B
   input wire logic converter_module_disable_i,     // converter powered off
   input wire logic [5:0] pin_level_i,              // levels on shared pins
   output ais_pkg::ais_mux_sel_t mux_sel_o,         // multiplexer selects
   output logic [5:0] mux_in_gnd_o,                 // mux input tied to analog ground
   output logic [5:0] scan_include_o,               // scan inclusion per input
   output logic [5:0] port_read_o,                  // gated digital port reads
   output logic [5:0] pin_digital_o                 // pin in digital mode
);
   import ais_pkg::*;

   logic [15:0] alt_reg;
   logic [15:0] main_reg;
   logic [15:0] scan_reg;
   logic [15:0] pin_digital_select_reg;
   logic wr_pend_reg;
   logic [31:0] wr_addr_reg;
   logic [31:0] rd_data_next;
   logic [5:0] present;
   logic [5:0] digital_next;
   ais_mux_sel_t sel_next;
   logic pos_bit;
   logic [1:0] neg_code;
   logic [4:0] main_code;

   // masks off unimplemented bits
   function automatic logic [15:0] reg_mask(input logic [31:0] addr);
      case (addr[7:0])
         AIS_OFF_ALT[7:0]: reg_mask = AIS_ALT_MASK;
         AIS_OFF_MAIN[7:0]: reg_mask = AIS_MAIN_MASK;
         AIS_OFF_SCAN[7:0]: reg_mask = AIS_SCAN_MASK;
         AIS_OFF_PIN_DIGITAL_SELECT[7:0]: reg_mask = AIS_PIN_DIGITAL_SELECT_MASK;
         default: reg_mask = 16'h0000;
      endcase
   endfunction

   function automatic logic [2:0] main_pos(input logic [4:0] code);
      if (code <= AIS_CODE_AN_MAX) begin
         main_pos = code[2:0];
      end else if (code == AIS_CODE_TEMP) begin
         main_pos = AIS_SEL_TEMP;
      end else begin
         main_pos = AIS_SEL_NC;  // none and reserved codes leave it open
      end
   endfunction

   // address phase capture, single-cycle answer
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 32'h0000_0000;
      end else begin
         wr_pend_reg <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
         wr_addr_reg <= haddr_i;
      end
   end

   always_comb begin
      rd_data_next = 32'h0000_0000;
      case (haddr_i[7:0])
         AIS_OFF_ALT[7:0]: rd_data_next = {16'h0000, alt_reg};
         AIS_OFF_MAIN[7:0]: rd_data_next = {16'h0000, main_reg};
         AIS_OFF_SCAN[7:0]: rd_data_next = {16'h0000, scan_reg};
         AIS_OFF_PIN_DIGITAL_SELECT[7:0]: rd_data_next = {16'h0000, pin_digital_select_reg};
         default: rd_data_next = 32'h0000_0000;
      endcase
      if (haddr_i[31:8] != 24'h000000) begin
         rd_data_next = 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         hrdata_o <= 32'h0000_0000;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
         if (hsel_i && hready_i && htrans_i[1] && !hwrite_i) begin
            hrdata_o <= rd_data_next;
         end
      end
   end

   // register writes: masked, so unimplemented bits stay zero
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         alt_reg <= AIS_RESET_VAL;
         main_reg <= AIS_RESET_VAL;
         scan_reg <= AIS_RESET_VAL;
         pin_digital_select_reg <= AIS_RESET_VAL;
      end else if (wr_pend_reg && wr_addr_reg[31:8] == 24'h000000) begin
         case (wr_addr_reg[7:0])
            AIS_OFF_ALT[7:0]: alt_reg <= hwdata_i[15:0] & reg_mask(wr_addr_reg);
            AIS_OFF_MAIN[7:0]: main_reg <= hwdata_i[15:0] & reg_mask(wr_addr_reg);
            AIS_OFF_SCAN[7:0]: scan_reg <= hwdata_i[15:0] & reg_mask(wr_addr_reg);
            AIS_OFF_PIN_DIGITAL_SELECT[7:0]: pin_digital_select_reg <= hwdata_i[15:0] & reg_mask(wr_addr_reg);
            default: ;
         endcase
      end
   end

   // inputs that exist on this part
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_present
         assign present[gi] = (gi < NUM_INPUTS) ? 1'b1 : 1'b0;
      end
   endgenerate

   // sample slot choice
   always_comb begin
      pos_bit = alt_sample_i ? alt_reg[AIS_ALT_POS_B] : alt_reg[AIS_ALT_POS_A];
      neg_code = alt_sample_i ? alt_reg[AIS_ALT_NEG_B_LO +: 2] : alt_reg[AIS_ALT_NEG_A_LO +: 2];
      main_code = alt_sample_i ? main_reg[AIS_MAIN_POS_B_LO +: 5] : main_reg[AIS_MAIN_POS_A_LO +: 5];
      sel_next.ch0_pos = main_pos(main_code);
      sel_next.ch0_neg_an1 = alt_sample_i ? main_reg[AIS_MAIN_NEG_B] : main_reg[AIS_MAIN_NEG_A];
      // reserved 1x codes also park on ground
      sel_next.ch123_neg_gnd = 1'b1;
      if (neg_code[1]) begin
         sel_next.ch123_neg_gnd = 1'b1;
      end
      if (!pos_bit) begin
         sel_next.ch1_pos = 3'h0;
         sel_next.ch2_pos = 3'h1;
         sel_next.ch3_pos = 3'h2;
      end else if (NUM_INPUTS >= AIS_NUM_AN) begin
         sel_next.ch1_pos = 3'h3;
         sel_next.ch2_pos = 3'h4;
         sel_next.ch3_pos = 3'h5;
      end else begin
         sel_next.ch1_pos = 3'h3;
         sel_next.ch2_pos = AIS_SEL_NC;
         sel_next.ch3_pos = AIS_SEL_NC;
      end
      // converter off forces every shared pin digital
      digital_next = converter_module_disable_i ? 6'h3f : (pin_digital_select_reg[5:0] | ~present);
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         mux_sel_o <= '0;
         mux_in_gnd_o <= 6'h00;
         scan_include_o <= 6'h00;
         pin_digital_o <= 6'h00;
      end else begin
         mux_sel_o <= sel_next;
         mux_in_gnd_o <= digital_next & present;
         scan_include_o <= scan_reg[5:0];
         pin_digital_o <= digital_next;
      end
   end

   // analog pins read as zero
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         port_read_o <= 6'h00;
      end else begin
         port_read_o <= pin_level_i & digital_next;
      end
   end
endmodule
`default_nettype wire

// File: inc/ais_pkg.sv
// package for the converter input select register block
package ais_pkg;
   localparam logic [31:0] AIS_OFF_ALT = 32'h0000_0000;
   localparam logic [31:0] AIS_OFF_MAIN = 32'h0000_0004;
   localparam logic [31:0] AIS_OFF_SCAN = 32'h0000_0008;
   localparam logic [31:0] AIS_OFF_PIN_DIGITAL_SELECT = 32'h0000_000c;
   localparam logic [15:0] AIS_ALT_MASK = 16'h0707;
   localparam logic [15:0] AIS_MAIN_MASK = 16'h9f9f;
   localparam logic [15:0] AIS_SCAN_MASK = 16'h003f;
   localparam logic [15:0] AIS_PIN_DIGITAL_SELECT_MASK = 16'h003f;
   localparam logic [15:0] AIS_RESET_VAL = 16'h0000;
   localparam int AIS_ALT_POS_B = 8;
   localparam int AIS_ALT_NEG_B_LO = 9;
   localparam int AIS_ALT_POS_A = 0;
   localparam int AIS_ALT_NEG_A_LO = 1;
   localparam int AIS_MAIN_NEG_B = 15;
   localparam int AIS_MAIN_POS_B_LO = 8;
   localparam int AIS_MAIN_NEG_A = 7;
   localparam int AIS_MAIN_POS_A_LO = 0;
   localparam logic [4:0] AIS_CODE_AN_MAX = 5'h05;
   localparam logic [4:0] AIS_CODE_TEMP = 5'h0d;
   localparam logic [4:0] AIS_CODE_NONE = 5'h0e;
   localparam int AIS_NUM_AN = 6;
   // input index meaning "not connected" / "temperature sensor"
   localparam logic [2:0] AIS_SEL_NC = 3'h7;
   localparam logic [2:0] AIS_SEL_TEMP = 3'h6;

   typedef struct packed {
      logic [2:0] ch0_pos;   // 0..5 input, 6 temp, 7 none
      logic ch0_neg_an1;     // 1: AN1, 0: analog ground
      logic [2:0] ch1_pos;
      logic [2:0] ch2_pos;
      logic [2:0] ch3_pos;
      logic ch123_neg_gnd;   // 1: negative inputs on analog ground
   } ais_mux_sel_t;
endpackage

// File: verif/ais_regs_properties.sv
// assertions on the input select register block
`timescale 1ns/1ns
`default_nettype none
module ais_regs_properties #(
   parameter int NUM_INPUTS = 6
) (
   input wire logic clk_i, // clock
   input wire logic sys_rst_i, // reset
   input wire logic hsel_i, // select
   input wire logic [31:0] haddr_i, // address
   input wire logic [1:0] htrans_i, // transfer
   input wire logic hwrite_i, // write
   input wire logic [31:0] hwdata_i, // write data
   input wire logic hready_i, // bus ready
   input wire logic [31:0] hrdata_o, // read data
   input wire logic converter_module_disable_i, // converter off
   input wire logic [5:0] pin_level_i, // pin levels
   input wire ais_pkg::ais_mux_sel_t mux_sel_o, // selects
   input wire logic [5:0] scan_include_o, // scan mask
   input wire logic [5:0] port_read_o, // port reads
   input wire logic [5:0] pin_digital_o // digital pins
);
   import ais_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   wire acc = hsel_i & hready_i & htrans_i[1];
   logic live_q;
   logic wd_en;
   logic [5:0] wd_q;
   always_ff @(posedge clk_i) live_q <= !sys_rst_i;
   always_ff @(posedge clk_i) wd_en <= acc & hwrite_i & (haddr_i == AIS_OFF_SCAN);
   always_ff @(posedge clk_i) if (wd_en) wd_q <= hwdata_i[5:0];
   sequence wr_scan;
      acc && hwrite_i && haddr_i == AIS_OFF_SCAN;
   endsequence
   sequence rd_alt;
      acc && !hwrite_i && haddr_i == AIS_OFF_ALT;
   endsequence
   scan_update_a: assert property (wr_scan |-> ##[3:5] scan_include_o == wd_q)
      else $error("scan mask output missed the write");
   read_level_a: assert property (live_q |-> port_read_o == ($past(pin_level_i) & pin_digital_o))
      else $error("port read not gated by pin mode");
   off_digital_a: assert property (live_q && $past(converter_module_disable_i) |-> pin_digital_o == 6'h3f)
      else $error("converter off but pin left analog");
   neg_gnd_a: assert property (live_q |-> mux_sel_o.ch123_neg_gnd)
      else $error("alternate negative inputs off ground");
   alt_route_a: assert property (live_q && NUM_INPUTS == 6 |-> mux_sel_o.ch1_pos inside {3'h0, 3'h3} &&
      mux_sel_o.ch2_pos == mux_sel_o.ch1_pos + 3'h1 && mux_sel_o.ch3_pos == mux_sel_o.ch1_pos + 3'h2)
      else $error("alternate channel routing wrong");
   upper_zero_a: assert property (hrdata_o[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   alt_mask_a: assert property (rd_alt |=> (hrdata_o[15:0] & ~AIS_ALT_MASK) == 16'h0000)
      else $error("unimplemented alternate bits read set");
   reset_zero_a: assert property (!live_q |-> scan_include_o == 6'h00 && pin_digital_o == 6'h00)
      else $error("outputs not clear after reset");
endmodule
bind ais_regs ais_regs_properties #(.NUM_INPUTS(NUM_INPUTS)) u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
   .hready_i(hready_i), .hrdata_o(hrdata_o), .converter_module_disable_i(converter_module_disable_i),
   .pin_level_i(pin_level_i), .mux_sel_o(mux_sel_o), .scan_include_o(scan_include_o),
   .port_read_o(port_read_o), .pin_digital_o(pin_digital_o));
`default_nettype wire

// File: verif/ais_pin_model.sv
// pin level source standing in for the shared analog pins
`timescale 1ns/1ns
`default_nettype none
module ais_pin_model (
   input wire logic clk_i, // clock
   input wire logic sys_rst_i, // reset
   output logic [5:0] pin_level_o // levels on shared pins
);
   // every pin flips each cycle so a stale level cannot pass for a fresh read
   always_ff @(posedge clk_i) pin_level_o <= sys_rst_i ? 6'h15 : ~pin_level_o;
endmodule
`default_nettype wire

// File: verif/test_adc_input_select_regs.sv
// self-checking bench for the input select registers
`timescale 1ns/1ns
`default_nettype none
module test_adc_input_select_regs;
   import ais_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, q;
   logic [1:0] htrans_i = 2'h0;
   logic hwrite_i = 1'b0, alt_sample_i = 1'b0, off_i = 1'b0, hreadyout_o, hresp;
   logic [5:0] pin_level, gnd_o, scan_o, read_o, dig_o;
   ais_mux_sel_t mux_sel_o;
   logic [15:0] masks [5] = '{AIS_ALT_MASK, AIS_MAIN_MASK, AIS_SCAN_MASK, AIS_PIN_DIGITAL_SELECT_MASK, 16'h0};
   logic [4:0] codes [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h0d, 5'h0e};
   int num_errors = 0, checks_done = 0, cyc = 0;
   ais_regs dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(1'b1), .haddr_i(haddr_i), .htrans_i(htrans_i),
      .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
      .hreadyout_o(hreadyout_o), .hresp_o(hresp), .alt_sample_i(alt_sample_i), .converter_module_disable_i(off_i),
      .pin_level_i(pin_level), .mux_sel_o(mux_sel_o), .mux_in_gnd_o(gnd_o), .scan_include_o(scan_o),
      .port_read_o(read_o), .pin_digital_o(dig_o));
   ais_pin_model u_pins (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pin_level_o(pin_level));
   initial forever #20 clk_i = ~clk_i;
   task automatic give_verdict();
      if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one ahb single word transfer; read data lands in q
   task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] d);
      haddr_i <= a;
      hwrite_i <= wr;
      htrans_i <= 2'h2;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      q = hrdata_o;
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         num_errors++;
         give_verdict();
      end
   end
   initial begin
      repeat (10) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      for (int i = 0; i < 5; i++) begin
         xfer(32'(i * 4), 1'b0, 32'h0);
         chk(q, 32'h0);
         xfer(32'(i * 4), 1'b1, 32'hffff_ffff);
         xfer(32'(i * 4), 1'b0, 32'h0);
         chk(q, {16'h0, masks[i]});
         chk(32'(hresp), 32'h0);
      end
      foreach (codes[i]) begin
         xfer(AIS_OFF_MAIN, 1'b1, {16'h0, 8'h0e, 3'h4, codes[i]});
         repeat (3) @(posedge clk_i);
         chk(32'({mux_sel_o.ch0_pos, mux_sel_o.ch0_neg_an1}), 32'({3'(i), 1'b1}));
      end
      xfer(AIS_OFF_MAIN, 1'b1, 32'h0000_8302);
      xfer(AIS_OFF_ALT, 1'b1, 32'h0000_0100);
      for (int s = 0; s < 2; s++) begin
         alt_sample_i <= s[0];
         repeat (3) @(posedge clk_i);
         chk(32'({mux_sel_o.ch0_pos, mux_sel_o.ch0_neg_an1}), s ? 32'h7 : 32'h4);
         chk(32'({mux_sel_o.ch1_pos, mux_sel_o.ch2_pos, mux_sel_o.ch3_pos}), s ? 32'o345 : 32'o012);
      end
      xfer(AIS_OFF_SCAN, 1'b1, 32'h0000_002a);
      xfer(AIS_OFF_PIN_DIGITAL_SELECT, 1'b1, 32'h0000_0005);
      repeat (3) @(posedge clk_i);
      chk(32'(scan_o), 32'h2a);
      chk(32'({dig_o, gnd_o}), 32'h145);
      chk(32'(read_o & 6'h3a), 32'h0);
      off_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk(32'(dig_o), 32'h3f);
      give_verdict();
   end
endmodule
`default_nettype wire
